// >>> ulstki_pkg.sv
// package: register map, field positions and timing for the usb token/flag block
package ulstki_pkg;
  // register addresses in the peripheral bank (9-bit data memory address)
  localparam logic [8:0] UEV_FLAGS_ADDR = 9'h190;
  localparam logic [8:0] UEV_ENABLES_ADDR = 9'h191;
  localparam logic [8:0] ERROR_SUMMARY_FLAG_FLAGS_ADDR = 9'h192;
  localparam logic [8:0] ERROR_SUMMARY_FLAG_ENABLES_ADDR = 9'h193;
  localparam logic [8:0] TRANSFER_STATUS_REGISTER_ADDR = 9'h194;
  localparam logic [8:0] USB_CONTROL_REGISTER_ADDR = 9'h195;
  localparam logic [1:0] USB_BANK = 2'h3;
  // event flag bit positions
  localparam int BIT_RST = 0;
  localparam int BIT_ERR = 1;
  localparam int BIT_WAKE = 2;
  localparam int BIT_TOKDONE = 3;
  localparam int BIT_IDLE = 4;
  localparam int BIT_STALL = 5;
  localparam logic [7:0] FLAG_MASK = 8'h3f;
  localparam logic [7:0] REG_RESET = 8'h00;
  // control register bit for suspend
  localparam int BIT_SUSPEND = 1;
  // descriptor ownership bit position in the status byte
  localparam int BIT_OWN = 7;
  // token pid codes (low nibble)
  localparam logic [3:0] PID_OUT = 4'h1;
  localparam logic [3:0] PID_IN = 4'h9;
  localparam logic [3:0] PID_SETUP = 4'hd;
  localparam logic [1:0] MAX_EP = 2'h2;
  // timing
  localparam int CLK_HZ = 20000000;
  localparam int IDLE_TIME_US = 3000;
  localparam int IDLE_CYCLES = (CLK_HZ / 1000000) * IDLE_TIME_US;
  localparam int IDLE_W = 16;
  // token engine states
  typedef enum logic [2:0] {
    ULSTKI_IDLE_S,
    ULSTKI_FETCH_S,
    ULSTKI_XFER_S,
    ULSTKI_DONE_S
  } ulstki_state_t;
endpackage

// >>> ulstki_top.sv
// usb low-speed token handling, descriptor ownership and event flag logic
`timescale 1ns/10ps
`default_nettype none
// Function
// - only control and interrupt transfers accepted
// - endpoints zero to two, in and out
// - move data only when engine owns descriptor
// - on completion write status, clear ownership
// - completion loads status register, sets token-done
// - registers and descriptors live in bank three
// - each flag gated by its enable bit on its way to the irq
// - enabled flags ored into core irq flag; in suspend only wake passes
// - flags sticky; outside suspend write zero clears, one keeps
// - idle flag after 3 ms without bus_wake_flag
// - error summary set by enabled error
// - enable bit lets source reach irq
// - event enables never block flag setting; error enables gate err
// - masked flags remain readable for polling
// - enable layout mirrors flags, upper bits zero
// - error flags masked, ored to summary
module ulstki_top
  import ulstki_pkg::*;
#(
  parameter int IDLE_LIMIT = IDLE_CYCLES
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic srst_in,
  // core data memory port
  input wire logic [1:0] mem_bank_in,
  input wire logic [8:0] mem_addr_in,
  input wire logic mem_wr_in,
  input wire logic [7:0] mem_wdata_in,
  output logic [7:0] mem_rdata_out,
  // bus-side line events from the transceiver side (async)
  input wire logic bus_bus_wake_flag_in,
  input wire logic bus_reset_in,
  input wire logic stall_sent_in,
  input wire logic [7:0] error_events_in,
  // decoded token from the serial engine
  input wire logic token_valid_in,
  input wire logic [3:0] token_pid_in,
  input wire logic [3:0] token_ep_in,
  input wire logic token_end_in,
  // descriptor table port toward the shared ram
  input wire logic [7:0] bd_status_in,
  output logic [2:0] bd_index_out,
  output logic bd_wr_out,
  output logic [7:0] bd_status_out,
  // data movement grant and token answer
  output logic xfer_enable_out,
  output logic token_nak_out,
  // interrupt to core
  output logic usb_core_irq_flag_out
);
  import ulstki_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers: async pins pass two flops before any use
  logic [10:0] sync1_reg, sync1_next;
  logic [10:0] sync2_reg, sync2_next;
  logic [10:0] sync3_reg, sync3_next; // delayed copy for edge detect
  always_comb begin
    sync1_next = {bus_bus_wake_flag_in, bus_reset_in, stall_sent_in, error_events_in};
    sync2_next = sync1_reg;
    sync3_next = sync2_reg;
  end
  always_ff @(posedge sys_clk_in) begin
    sync1_reg <= srst_in ? 11'h000 : sync1_next;
    sync2_reg <= srst_in ? 11'h000 : sync2_next;
    sync3_reg <= srst_in ? 11'h000 : sync3_next;
  end
  // rising edges of the synchronised events
  logic [10:0] rise;
  assign rise = sync2_reg & ~sync3_reg;
  logic act_level;
  assign act_level = sync2_reg[10];

  ////////////////////////////////////////////////////////////////////////
  // register access decode; only bank three reaches this block
  function automatic logic hit(input logic [1:0] bank, input logic [8:0] a,
                               input logic [8:0] target);
    hit = (bank == USB_BANK) && (a == target);
  endfunction

  logic wr_flags, wr_en, wr_eflags, wr_een, wr_ctrl;
  assign wr_flags = mem_wr_in && hit(mem_bank_in, mem_addr_in, UEV_FLAGS_ADDR);
  assign wr_en = mem_wr_in && hit(mem_bank_in, mem_addr_in, UEV_ENABLES_ADDR);
  assign wr_eflags = mem_wr_in && hit(mem_bank_in, mem_addr_in, ERROR_SUMMARY_FLAG_FLAGS_ADDR);
  assign wr_een = mem_wr_in && hit(mem_bank_in, mem_addr_in, ERROR_SUMMARY_FLAG_ENABLES_ADDR);
  assign wr_ctrl = mem_wr_in && hit(mem_bank_in, mem_addr_in, USB_CONTROL_REGISTER_ADDR);

  ////////////////////////////////////////////////////////////////////////
  // token engine: checks ownership, grants data move, posts status
  ulstki_state_t state_reg, state_next;
  logic [2:0] bd_index_reg, bd_index_next;
  logic bd_wr_reg, bd_wr_next;
  logic [7:0] bd_status_reg, bd_status_next;
  logic xfer_reg, xfer_next;
  logic nak_reg, nak_next;
  logic [7:0] transfer_status_register_reg, transfer_status_register_next; // endpoint and direction of last completed token
  logic tokdone_set;
  logic legal_token;
  // accept only endpoints 0..2 and control/interrupt pids
  assign legal_token = (token_ep_in[3:2] == 2'h0) && (token_ep_in[1:0] <= MAX_EP)
    && (token_pid_in == PID_IN || token_pid_in == PID_OUT
        || token_pid_in == PID_SETUP);

  always_comb begin
    state_next = state_reg;
    bd_index_next = bd_index_reg;
    bd_wr_next = 1'b0;
    bd_status_next = bd_status_reg;
    xfer_next = xfer_reg;
    nak_next = 1'b0;
    transfer_status_register_next = transfer_status_register_reg;
    tokdone_set = 1'b0;
    case (state_reg)
      ULSTKI_IDLE_S: begin
        // pick descriptor: two per endpoint, in at odd index
        if (token_valid_in && legal_token) begin
          bd_index_next = {token_ep_in[1:0], token_pid_in == PID_IN};
          state_next = ULSTKI_FETCH_S;
        end
      end
      ULSTKI_FETCH_S: begin
        if (bd_status_in[BIT_OWN]) begin
          xfer_next = 1'b1;
          state_next = ULSTKI_XFER_S;
        end else begin
          // firmware still owns it: answer nak, no flag
          nak_next = 1'b1;
          state_next = ULSTKI_IDLE_S;
        end
      end
      ULSTKI_XFER_S: begin
        if (token_end_in) begin
          xfer_next = 1'b0;
          // hand buffer back: status with ownership cleared
          bd_status_next = {1'b0, bd_status_in[6:4], token_pid_in};
          bd_wr_next = 1'b1;
          state_next = ULSTKI_DONE_S;
        end
      end
      ULSTKI_DONE_S: begin
        transfer_status_register_next = {3'h0, bd_index_reg, 2'h0};
        tokdone_set = 1'b1;
        state_next = ULSTKI_IDLE_S;
      end
      default: state_next = ULSTKI_IDLE_S;
    endcase
  end
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      state_reg <= ULSTKI_IDLE_S;
      bd_index_reg <= 3'h0;
      bd_wr_reg <= 1'b0;
      bd_status_reg <= REG_RESET;
      xfer_reg <= 1'b0;
      nak_reg <= 1'b0;
      transfer_status_register_reg <= REG_RESET;
    end else begin
      state_reg <= state_next;
      bd_index_reg <= bd_index_next;
      bd_wr_reg <= bd_wr_next;
      bd_status_reg <= bd_status_next;
      xfer_reg <= xfer_next;
      nak_reg <= nak_next;
      transfer_status_register_reg <= transfer_status_register_next;
    end
  end
  // ownership return by firmware happens through the shared ram, not here

  ////////////////////////////////////////////////////////////////////////
  // idle timer: restarts on any bus bus_wake_flag
  logic [IDLE_W-1:0] idle_cnt_reg, idle_cnt_next;
  logic idle_set;
  always_comb begin
    idle_set = 1'b0;
    if (act_level || rise[10]) begin
      idle_cnt_next = '0;
    end else if (idle_cnt_reg == IDLE_W'(IDLE_LIMIT - 1)) begin
      // saturate so the flag fires once per idle stretch
      idle_cnt_next = idle_cnt_reg + 1'b1;
      idle_set = 1'b1;
    end else if (idle_cnt_reg < IDLE_W'(IDLE_LIMIT)) begin
      idle_cnt_next = idle_cnt_reg + 1'b1;
    end else begin
      idle_cnt_next = idle_cnt_reg;
    end
  end
  always_ff @(posedge sys_clk_in) begin
    idle_cnt_reg <= srst_in ? '0 : idle_cnt_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // flag, enable, error and control registers
  logic [7:0] flags_reg, flags_next;
  logic [7:0] en_reg, en_next;
  logic [7:0] eflags_reg, eflags_next;
  logic [7:0] een_reg, een_next;
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] set_vec;
  logic suspended;
  assign suspended = ctrl_reg[BIT_SUSPEND];

  // sticky update: a set in the same cycle as a clear wins
  function automatic logic [7:0] sticky(input logic [7:0] cur, input logic wr,
                                        input logic [7:0] wd, input logic [7:0] set);
    sticky = ((wr ? (cur & wd) : cur) | set);
  endfunction

  always_comb begin
    set_vec = 8'h00;
    set_vec[BIT_STALL] = rise[8];
    set_vec[BIT_IDLE] = idle_set;
    set_vec[BIT_TOKDONE] = tokdone_set;
    set_vec[BIT_WAKE] = suspended && rise[10];
    set_vec[BIT_ERR] = |(eflags_reg & een_reg);
    set_vec[BIT_RST] = rise[9];
    // event enables are not consulted here: flags always set; only err reads the error enables
    eflags_next = sticky(eflags_reg, wr_eflags && !suspended, mem_wdata_in, rise[7:0]);
    flags_next = sticky(flags_reg, wr_flags && !suspended, mem_wdata_in, set_vec)
      & FLAG_MASK;
    en_next = wr_en ? (mem_wdata_in & FLAG_MASK) : en_reg;
    een_next = wr_een ? mem_wdata_in : een_reg;
    ctrl_next = wr_ctrl ? mem_wdata_in : ctrl_reg;
  end
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      flags_reg <= REG_RESET;
      en_reg <= REG_RESET;
      eflags_reg <= REG_RESET;
      een_reg <= REG_RESET;
      ctrl_reg <= REG_RESET;
    end else begin
      flags_reg <= flags_next;
      en_reg <= en_next;
      eflags_reg <= eflags_next;
      een_reg <= een_next;
      ctrl_reg <= ctrl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // merged interrupt; in suspend only the wake source passes
  logic [7:0] gate_mask;
  logic irq_reg, irq_next;
  logic [7:0] rdata_reg, rdata_next;
  always_comb begin
    gate_mask = suspended ? (8'h01 << BIT_WAKE) : FLAG_MASK;
    irq_next = |(flags_reg & en_reg & gate_mask);
    // read mux; flags readable whatever the enables
    if (mem_bank_in != USB_BANK) begin
      rdata_next = 8'h00;
    end else begin
      case (mem_addr_in)
        UEV_FLAGS_ADDR: rdata_next = flags_reg;
        UEV_ENABLES_ADDR: rdata_next = en_reg;
        ERROR_SUMMARY_FLAG_FLAGS_ADDR: rdata_next = eflags_reg;
        ERROR_SUMMARY_FLAG_ENABLES_ADDR: rdata_next = een_reg;
        TRANSFER_STATUS_REGISTER_ADDR: rdata_next = transfer_status_register_reg;
        USB_CONTROL_REGISTER_ADDR: rdata_next = ctrl_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end
  always_ff @(posedge sys_clk_in) begin
    irq_reg <= srst_in ? 1'b0 : irq_next;
    rdata_reg <= srst_in ? 8'h00 : rdata_next;
  end

  // outputs straight from flops
  assign usb_core_irq_flag_out = irq_reg;
  assign mem_rdata_out = rdata_reg;
  assign bd_index_out = bd_index_reg;
  assign bd_wr_out = bd_wr_reg;
  assign bd_status_out = bd_status_reg;
  assign xfer_enable_out = xfer_reg;
  assign token_nak_out = nak_reg;

  ////////////////////////////////////////////////////////////////////////
  // assertions
  a_flag_sticky: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    !wr_flags && flags_reg[BIT_IDLE] |=> flags_reg[BIT_IDLE])
    else $error("idle flag dropped without a write");
  a_irq_merge: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    !suspended && |(flags_reg & en_reg) |=> usb_core_irq_flag_out)
    else $error("enabled flag did not raise irq");
  a_irq_masked: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (flags_reg & en_reg) == 8'h00 |=> !usb_core_irq_flag_out)
    else $error("irq without enabled flag");
  a_own_check: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    state_reg == ULSTKI_FETCH_S && !bd_status_in[BIT_OWN] |=> !xfer_enable_out)
    else $error("transfer granted without ownership");
  a_own_return: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    bd_wr_out |-> !bd_status_out[BIT_OWN])
    else $error("ownership not returned");
  // write-back pulse and flag set share one cycle, so the flag shows next edge
  a_tokdone_set: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    bd_wr_out |=> flags_reg[BIT_TOKDONE])
    else $error("token done flag not set");
  a_enable_upper: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    en_reg[7:6] == 2'h0)
    else $error("enable upper bits nonzero");
  a_suspend_gate: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    suspended && !flags_reg[BIT_WAKE] ##1 $stable(ctrl_reg) |-> !usb_core_irq_flag_out)
    else $error("non wake irq while suspended");
  a_ep_legal: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    state_reg == ULSTKI_FETCH_S |-> bd_index_reg[2:1] <= MAX_EP)
    else $error("illegal endpoint accepted");
  c_token_done: cover property (@(posedge sys_clk_in) disable iff (srst_in)
    state_reg == ULSTKI_DONE_S);
  c_nak: cover property (@(posedge sys_clk_in) disable iff (srst_in) token_nak_out);
  c_idle: cover property (@(posedge sys_clk_in) disable iff (srst_in) idle_set);
endmodule // ulstki_top
`default_nettype wire

// >>> ulstki_bd_ram.sv
// descriptor table model facing the token engine
`timescale 1ns/10ps
`default_nettype none
module ulstki_bd_ram (
  // clock
  input wire logic sys_clk_in,
  // engine side of the table
  input wire logic [2:0] bd_index_in,
  input wire logic bd_wr_in,
  input wire logic [7:0] bd_status_in,
  output logic [7:0] bd_status_out
);
  logic [7:0] mem [0:7]; // one status byte per ep/dir
  // read is combinational so the fetch cycle sees the addressed entry
  assign bd_status_out = mem[bd_index_in];
  // write-back returns the buffer to firmware
  always @(posedge sys_clk_in) begin
    if (bd_wr_in) begin
      mem[bd_index_in] <= bd_status_in;
    end
  end
endmodule // ulstki_bd_ram
`default_nettype wire

// >>> test_usb_lowspeed_token_and_interrupt.sv
// self-checking bench for the token engine and event flags
`timescale 1ns/10ps
`default_nettype none
module test_usb_lowspeed_token_and_interrupt;
  import ulstki_pkg::*;
  localparam int LIM = 20; // short idle limit keeps the run brief
  logic sys_clk_in, srst_in, mem_wr_in, bus_bus_wake_flag_in, bus_reset_in;
  logic stall_sent_in, token_valid_in, token_end_in, irq;
  logic bd_wr_out, xfer_enable_out, token_nak_out;
  logic [1:0] mem_bank_in;
  logic [8:0] mem_addr_in;
  logic [7:0] mem_wdata_in, mem_rdata_out, error_events_in, bd_in, bd_out;
  logic [3:0] token_pid_in, token_ep_in;
  logic [2:0] bd_index_out;
  int error_cnt = 0;
  int num_checks = 0;
  integer seed = 32'hfd833447;
  logic rd_go, rd_v;
  logic [7:0] exp_q [$]; // expected read data, oldest first
  logic [3:0] pids [3] = '{PID_OUT, PID_IN, PID_SETUP};
  ulstki_top #(.IDLE_LIMIT(LIM)) i_dut (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
    .mem_bank_in(mem_bank_in), .mem_addr_in(mem_addr_in), .mem_wr_in(mem_wr_in),
    .mem_wdata_in(mem_wdata_in), .mem_rdata_out(mem_rdata_out),
    .bus_bus_wake_flag_in(bus_bus_wake_flag_in), .bus_reset_in(bus_reset_in),
    .stall_sent_in(stall_sent_in), .error_events_in(error_events_in),
    .token_valid_in(token_valid_in), .token_pid_in(token_pid_in),
    .token_ep_in(token_ep_in), .token_end_in(token_end_in), .bd_status_in(bd_in),
    .bd_index_out(bd_index_out), .bd_wr_out(bd_wr_out), .bd_status_out(bd_out),
    .xfer_enable_out(xfer_enable_out), .token_nak_out(token_nak_out),
    .usb_core_irq_flag_out(irq));
  ulstki_bd_ram i_ram (.sys_clk_in(sys_clk_in), .bd_index_in(bd_index_out),
    .bd_wr_in(bd_wr_out), .bd_status_in(bd_out), .bd_status_out(bd_in));
  ////////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  // compare and count
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task summarize;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // step to just after a rising edge, where inputs change
  task cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task wr(input logic [8:0] a, input logic [7:0] d);
    cyc(1);
    mem_addr_in = a;
    mem_wdata_in = d;
    mem_wr_in = 1'b1;
    cyc(1);
    mem_wr_in = 1'b0;
  endtask
  // read note goes on the queue; the monitor checks it
  task rd(input logic [8:0] a, input logic [7:0] e);
    cyc(1);
    mem_addr_in = a;
    rd_go = 1'b1;
    exp_q.push_back(e);
    cyc(1);
    rd_go = 1'b0;
  endtask
  // monitor: registered read data settles after the edge
  always @(posedge sys_clk_in) begin
    rd_v = rd_go;
    #2;
    if (rd_v === 1'b1) chk(mem_rdata_out, exp_q.pop_front());
  end
  ////////////////////////////////////////////////////////////////////////////
  // one token; ownership drawn at random when legal
  task tok(input logic [3:0] p, input logic [3:0] ep, input logic ok);
    logic [7:0] st;
    logic [2:0] ix;
    st = 8'($random(seed));
    ix = {ep[1:0], p == PID_IN};
    if (ok) i_ram.mem[ix] = st;
    cyc(1);
    token_valid_in = 1'b1;
    token_pid_in = p;
    token_ep_in = ep;
    cyc(1);
    token_valid_in = 1'b0;
    // fetch edge: grant level or one-cycle nak pulse stands now
    cyc(1);
    chk(8'(xfer_enable_out), 8'(ok & st[7]));
    chk(8'(token_nak_out), 8'(ok & ~st[7]));
    if (ok) chk(8'(bd_index_out), 8'(ix));
    if (ok && st[7]) begin
      token_end_in = 1'b1;
      cyc(1);
      token_end_in = 1'b0;
      // write-back pulse stands for this one cycle only
      chk(8'(bd_wr_out), 8'h01);
      chk(bd_out, {1'b0, st[6:4], p});
      cyc(1);
      rd(TRANSFER_STATUS_REGISTER_ADDR, {3'h0, ix, 2'h0});
      rd(UEV_FLAGS_ADDR, 8'h08);
      wr(UEV_FLAGS_ADDR, 8'hf7);
    end else begin
      cyc(2);
    end
  endtask
  // watchdog
  initial begin
    #(50 * 6000);
    error_cnt++;
    summarize;
  end
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {mem_wr_in, bus_reset_in, stall_sent_in, token_valid_in, token_end_in} = 5'h00;
    {mem_addr_in, mem_wdata_in, error_events_in, token_pid_in, token_ep_in} = '0;
    mem_bank_in = USB_BANK;
    bus_bus_wake_flag_in = 1'b1; // bus_wake_flag keeps the idle timer quiet
    rd_go = 1'b0;
    srst_in = 1'b1;
    cyc(2);
    srst_in = 1'b0;
    rd(UEV_FLAGS_ADDR, REG_RESET);
    rd(UEV_ENABLES_ADDR, REG_RESET);
    rd(9'h1a0, 8'h00);
    wr(UEV_ENABLES_ADDR, 8'hff);
    rd(UEV_ENABLES_ADDR, FLAG_MASK);
    wr(UEV_ENABLES_ADDR, 8'h00);
    bus_reset_in = 1'b1;
    cyc(2);
    bus_reset_in = 1'b0;
    stall_sent_in = 1'b1;
    cyc(2);
    stall_sent_in = 1'b0;
    cyc(4);
    rd(UEV_FLAGS_ADDR, 8'h21);
    chk(8'(irq), 8'h00);
    mem_bank_in = 2'h0;
    rd(UEV_FLAGS_ADDR, 8'h00);
    mem_bank_in = USB_BANK;
    wr(UEV_FLAGS_ADDR, 8'hff);
    rd(UEV_FLAGS_ADDR, 8'h21);
    wr(UEV_ENABLES_ADDR, 8'h20);
    cyc(3);
    chk(8'(irq), 8'h01);
    wr(UEV_FLAGS_ADDR, 8'hdf);
    rd(UEV_FLAGS_ADDR, 8'h01);
    cyc(2);
    chk(8'(irq), 8'h00);
    wr(UEV_FLAGS_ADDR, 8'h00);
    error_events_in = 8'h08;
    cyc(2);
    error_events_in = 8'h00;
    cyc(4);
    rd(ERROR_SUMMARY_FLAG_FLAGS_ADDR, 8'h08);
    rd(UEV_FLAGS_ADDR, 8'h00);
    wr(ERROR_SUMMARY_FLAG_ENABLES_ADDR, 8'h08);
    cyc(2);
    rd(UEV_FLAGS_ADDR, 8'h02);
    wr(ERROR_SUMMARY_FLAG_FLAGS_ADDR, 8'h00);
    wr(UEV_FLAGS_ADDR, 8'h00);
    rd(UEV_FLAGS_ADDR, 8'h00);
    for (int i = 0; i < 10; i++) begin
      tok(pids[$unsigned($random(seed)) % 3], 4'($unsigned($random(seed)) % 3), 1'b1);
    end
    tok(PID_IN, 4'h3, 1'b0);
    tok(4'h3, 4'h0, 1'b0);
    bus_bus_wake_flag_in = 1'b0;
    cyc(LIM / 2);
    rd(UEV_FLAGS_ADDR, 8'h00);
    cyc(LIM);
    rd(UEV_FLAGS_ADDR, 8'h10);
    wr(UEV_ENABLES_ADDR, 8'h10);
    cyc(2);
    chk(8'(irq), 8'h01);
    wr(USB_CONTROL_REGISTER_ADDR, 8'h02);
    cyc(3);
    chk(8'(irq), 8'h00);
    wr(UEV_ENABLES_ADDR, 8'h14);
    bus_bus_wake_flag_in = 1'b1;
    cyc(6);
    rd(UEV_FLAGS_ADDR, 8'h14);
    chk(8'(irq), 8'h01);
    // let the monitor take the last read before the verdict
    cyc(1);
    chk(8'(exp_q.size()), 8'h00);
    summarize;
  end
endmodule // test_usb_lowspeed_token_and_interrupt
`default_nettype wire
